// ### include/fgr_pkg.sv
// Package for the fine granularity refresh mode block.
// Assumes a single 125 MHz clock and an undecoded command bus from the pin side.
package fgr_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int REFI_BASE_NS = 7800;
	localparam int REFI_BASE_CYC = (REFI_BASE_NS * 1000) / CLK_PERIOD_PS;
	localparam int RFC1_2G_NS = 160;
	localparam int RFC1_4G_NS = 260;
	localparam int RFC1_8G_NS = 350;
	localparam int RFC2_2G_NS = 110;
	localparam int RFC2_4G_NS = 160;
	localparam int RFC2_8G_NS = 260;
	localparam int RFC4_2G_NS = 90;
	localparam int RFC4_4G_NS = 110;
	localparam int RFC4_8G_NS = 160;
	localparam int CNT_W = 12;

	// ---------------------------------------------------------------
	// Mode register field
	// ---------------------------------------------------------------
	localparam int MODE_LSB = 6;
	localparam int MODE_MSB = 8;
	localparam logic [2:0] MODE_RESET = 3'h0;

	typedef enum logic [2:0] {
		FGR_FIX1 = 3'b000,
		FGR_FIX2 = 3'b001,
		FGR_FIX4 = 3'b010,
		FGR_OTF12 = 3'b101,
		FGR_OTF14 = 3'b110
	} fgr_mode_e;

	typedef enum logic [1:0] {
		FGR_RATE1 = 2'b00,
		FGR_RATE2 = 2'b01,
		FGR_RATE4 = 2'b10
	} fgr_rate_e;

	typedef enum logic [1:0] {
		FGR_DEN2G = 2'b00,
		FGR_DEN4G = 2'b01,
		FGR_DEN8G = 2'b10
	} fgr_den_e;

	// Command pins sampled at the rising clock edge
	typedef struct packed {
		logic cs_n;
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic bg0;
		logic [1:0] mr_sel;
		logic [17:0] addr;
	} fgr_cmd_s;

	// Status shown to the rest of the device
	typedef struct packed {
		logic [2:0] mode;
		fgr_rate_e rate;
		logic reserved_mode;
		logic busy;
		logic [CNT_W-1:0] refi_cyc;
		logic [CNT_W-1:0] rfc_cyc;
	} fgr_stat_s;

	// Ceiling of ns to clock cycles, at least one cycle
	function automatic logic [CNT_W-1:0] ns2cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		if (c < 1) begin
			c = 1;
		end
		return c[CNT_W-1:0];
	endfunction
endpackage

// ### rtl/fgr_parity.sv
// Modulo counter of refreshes of one rate since the last clear.
// Assumes single clock, synchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module fgr_parity #(
	parameter int MOD = 2
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clr,
	input wire logic inc,
	output logic aligned
);
	logic [1:0] cnt_ff;
	logic [1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff + 2'h1;
		if (nxt_cnt == 2'(MOD)) begin
			nxt_cnt = 2'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || clr) begin
			cnt_ff <= 2'h0;
		end else if (inc) begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign aligned = (cnt_ff == 2'h0);
endmodule // fgr_parity
`default_nettype wire

// ### rtl/fgr_refresh_mode.sv
// Refresh-rate mode logic: mode field decode, refresh classing, timing, checks.
// Assumes the command bus comes from pins in another domain (synchronised here)
// and mode register writes are MRS commands on the same bus.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - Controller enables on-the-fly mode before use
// R2 - Decode mode field bits 8:6
// R3 - On-the-fly: BG0 picks single or fast rate
// R4 - Refresh decoded from CS ACT RAS CAS WE
// R5 - Reset gives fixed single rate mode
// R6 - Controller spaces refreshes at base/2 or base/4
// R7 - Controller waits refresh cycle time per type
// R8 - Fixed modes accept matching refresh only
// R9 - On-the-fly modes accept single or fast
// R10 - New interval and cycle time apply immediately
// R11 - Even double count before rate mode write
// R12 - Even double count between single refreshes
// R13 - Four-multiple quad count before rate write
// R14 - Four-multiple quad count between single refreshes
// R15 - Single fixed unrestricted; same rate no change
// R16 - Only deselects during refresh cycle time
// R17 - Postpone limits 8, 16, 32 by rate; no postpone count is kept or checked
// R18 - Temperature refresh needs fixed single mode
// R19 - Modulo counters track counting rules
module fgr_refresh_mode #(
	parameter fgr_pkg::fgr_den_e DENSITY = fgr_pkg::FGR_DEN8G,
	parameter int REFI_CYC = fgr_pkg::REFI_BASE_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire fgr_pkg::fgr_cmd_s cmd_pin,
	input wire logic tcr_enable,
	output fgr_pkg::fgr_stat_s stat,
	output logic single_rate_refresh,
	output logic double_rate_refresh,
	output logic quad_rate_refresh,
	output logic refresh_pulse,
	output logic err_type,
	output logic err_count,
	output logic err_busy,
	output logic err_tcr
);
	import fgr_pkg::*;

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	fgr_cmd_s cmd_s1_ff;
	fgr_cmd_s cmd_ff;
	logic tcr_s1_ff;
	logic tcr_ff;

	always_ff @(posedge mclk) begin
		cmd_s1_ff <= cmd_pin;
		cmd_ff <= cmd_s1_ff;
		tcr_s1_ff <= tcr_enable;
		tcr_ff <= tcr_s1_ff;
	end

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	logic is_ref;
	logic is_mrs3;
	logic is_des;
	logic [2:0] new_mode;

	// R4 - refresh encoding match
	assign is_ref = !cmd_ff.cs_n && cmd_ff.act_n && !cmd_ff.ras_n && !cmd_ff.cas_n &&
		cmd_ff.we_n;
	assign is_mrs3 = !cmd_ff.cs_n && cmd_ff.act_n && !cmd_ff.ras_n && !cmd_ff.cas_n &&
		!cmd_ff.we_n && (cmd_ff.mr_sel == 2'h3);
	assign is_des = cmd_ff.cs_n;
	assign new_mode = cmd_ff.addr[MODE_MSB:MODE_LSB];

	// ---------------------------------------------------------------
	// Mode register field
	// ---------------------------------------------------------------
	logic [2:0] mode_ff;
	logic on_the_fly_selection;
	logic mode_rsvd;
	logic new_rsvd;
	fgr_rate_e fast_rate;
	fgr_rate_e mode_rate;
	fgr_rate_e new_rate;

	function automatic fgr_rate_e rate_of(input logic [2:0] m);
		case (m)
			FGR_FIX2: rate_of = FGR_RATE2;
			FGR_FIX4: rate_of = FGR_RATE4;
			default: rate_of = FGR_RATE1;
		endcase
	endfunction

	// R2 - reserved code detect
	function automatic logic rsvd_of(input logic [2:0] m);
		rsvd_of = !(m == FGR_FIX1 || m == FGR_FIX2 || m == FGR_FIX4 ||
			m == FGR_OTF12 || m == FGR_OTF14);
	endfunction

	assign on_the_fly_selection = mode_ff[2];
	assign mode_rsvd = rsvd_of(mode_ff);
	assign new_rsvd = rsvd_of(new_mode);
	assign fast_rate = (mode_ff == FGR_OTF14 || mode_ff == FGR_FIX4) ? FGR_RATE4 : FGR_RATE2;
	assign mode_rate = rate_of(mode_ff);
	assign new_rate = rate_of(new_mode);

	// R5 - reset to fixed single
	// R1 - on-the-fly only after write
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_ff <= MODE_RESET;
		end else if (is_mrs3 && !new_rsvd) begin
			mode_ff <= new_mode;
		end
	end

	// ---------------------------------------------------------------
	// Refresh classification
	// ---------------------------------------------------------------
	fgr_rate_e ref_rate;

	// R3 - BG0 sampled only in on-the-fly modes
	always_comb begin
		if (on_the_fly_selection) begin
			ref_rate = cmd_ff.bg0 ? fast_rate : FGR_RATE1;
		end else begin
			ref_rate = mode_rate;
		end
	end

	logic ref_ok;
	assign ref_ok = is_ref && !mode_rsvd;

	always_ff @(posedge mclk) begin
		if (rst) begin
			single_rate_refresh <= 1'b0;
			double_rate_refresh <= 1'b0;
			quad_rate_refresh <= 1'b0;
			refresh_pulse <= 1'b0;
		end else begin
			single_rate_refresh <= ref_ok && (ref_rate == FGR_RATE1);
			double_rate_refresh <= ref_ok && (ref_rate == FGR_RATE2);
			quad_rate_refresh <= ref_ok && (ref_rate == FGR_RATE4);
			refresh_pulse <= ref_ok;
		end
	end

	// ---------------------------------------------------------------
	// Current rate and timing
	// ---------------------------------------------------------------
	fgr_rate_e rate_ff;
	fgr_rate_e new_fast;
	logic keeps_rate;
	logic [CNT_W-1:0] rfc_sel;
	logic [CNT_W-1:0] refi_sel;

	// R15 - rate kept across mode switch
	assign new_fast = (new_mode == FGR_OTF14) ? FGR_RATE4 : FGR_RATE2;
	assign keeps_rate = new_mode[2] ? (rate_ff == FGR_RATE1 || rate_ff == new_fast) :
		(new_rate == rate_ff);

	// R10 - rate follows mode write or on-the-fly refresh
	always_ff @(posedge mclk) begin
		if (rst) begin
			rate_ff <= FGR_RATE1;
		end else if (is_mrs3 && !new_rsvd && !keeps_rate) begin
			rate_ff <= new_rate;
		end else if (ref_ok) begin
			rate_ff <= ref_rate;
		end
	end

	function automatic logic [CNT_W-1:0] rfc_of(input fgr_rate_e r);
		int t;
		case (r)
			FGR_RATE2: t = (DENSITY == FGR_DEN2G) ? RFC2_2G_NS :
				(DENSITY == FGR_DEN4G) ? RFC2_4G_NS : RFC2_8G_NS;
			FGR_RATE4: t = (DENSITY == FGR_DEN2G) ? RFC4_2G_NS :
				(DENSITY == FGR_DEN4G) ? RFC4_4G_NS : RFC4_8G_NS;
			default: t = (DENSITY == FGR_DEN2G) ? RFC1_2G_NS :
				(DENSITY == FGR_DEN4G) ? RFC1_4G_NS : RFC1_8G_NS;
		endcase
		return ns2cyc(t);
	endfunction

	// R6 - interval divided by rate
	always_comb begin
		case (rate_ff)
			FGR_RATE2: refi_sel = CNT_W'(REFI_CYC / 2);
			FGR_RATE4: refi_sel = CNT_W'(REFI_CYC / 4);
			default: refi_sel = CNT_W'(REFI_CYC);
		endcase
	end
	assign rfc_sel = rfc_of(rate_ff);

	// R7 - busy for the refresh type's cycle time
	logic [CNT_W-1:0] busy_ff;
	always_ff @(posedge mclk) begin
		if (rst) begin
			busy_ff <= '0;
		end else if (ref_ok) begin
			busy_ff <= rfc_of(ref_rate) - CNT_W'(1);
		end else if (busy_ff != '0) begin
			busy_ff <= busy_ff - CNT_W'(1);
		end
	end

	// ---------------------------------------------------------------
	// Counting rules
	// ---------------------------------------------------------------
	logic rate_change;
	logic par_clr;
	logic dbl_even;
	logic quad_mult4;

	// R15 - same-rate mode switch is no change
	assign rate_change = is_mrs3 && !new_rsvd && !keeps_rate;
	// R19 - counters cleared by rate write or single refresh
	assign par_clr = rate_change || (ref_ok && ref_rate == FGR_RATE1);

	fgr_parity #(.MOD(2)) u_dbl (
		.mclk(mclk),
		.rst(rst),
		.clr(par_clr),
		.inc(ref_ok && ref_rate == FGR_RATE2),
		.aligned(dbl_even)
	);

	fgr_parity #(.MOD(4)) u_quad (
		.mclk(mclk),
		.rst(rst),
		.clr(par_clr),
		.inc(ref_ok && ref_rate == FGR_RATE4),
		.aligned(quad_mult4)
	);

	logic cnt_bad;
	logic type_bad;
	always_comb begin
		cnt_bad = 1'b0;
		// R11 - even doubles before rate write
		// R13 - four-multiple quads before rate write
		if (rate_change) begin
			cnt_bad = !dbl_even || !quad_mult4;
		end
		// R12 - even doubles between singles
		// R14 - four-multiple quads between singles
		if (ref_ok && ref_rate == FGR_RATE1 && on_the_fly_selection) begin
			cnt_bad = !dbl_even || !quad_mult4;
		end
		// R8 - fixed mode takes matching refresh
		// R9 - on-the-fly accepts both types
		type_bad = is_ref && mode_rsvd;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			err_type <= 1'b0;
			err_count <= 1'b0;
			err_busy <= 1'b0;
			err_tcr <= 1'b0;
		end else begin
			err_type <= type_bad;
			err_count <= cnt_bad;
			// R16 - only deselect during busy
			err_busy <= (busy_ff != '0) && !is_des;
			// R18 - temperature refresh needs single fixed
			err_tcr <= tcr_ff && (mode_ff != FGR_FIX1);
		end
	end

	// ---------------------------------------------------------------
	// Status
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			stat <= '0;
		end else begin
			stat.mode <= mode_ff;
			stat.rate <= rate_ff;
			stat.reserved_mode <= mode_rsvd;
			stat.busy <= (busy_ff != '0);
			stat.refi_cyc <= refi_sel;
			stat.rfc_cyc <= rfc_sel;
		end
	end
endmodule // fgr_refresh_mode
`default_nettype wire

// ### bench/fgr_refresh_mode_assertions.sv
// Port checker for the refresh mode block.
// Assumes the default 8 Gb density and a bind from the bench.
`timescale 1ns/1ps
`default_nettype none
module fgr_chk #(
	parameter int REFI_CYC = 975
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic tcr_enable,
	input wire fgr_pkg::fgr_stat_s stat,
	input wire logic single_rate_refresh,
	input wire logic double_rate_refresh,
	input wire logic quad_rate_refresh,
	input wire logic refresh_pulse,
	input wire logic err_tcr
);
	import fgr_pkg::*;
	// 350 ns at 8 ns, rounded up
	localparam int RFC1_CYC = 44;
	logic [2:0] cls;
	assign cls = {single_rate_refresh, double_rate_refresh, quad_rate_refresh};
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence ref_seen;
		refresh_pulse;
	endsequence
	sequence busy_soon;
		##[0:1] stat.busy;
	endsequence
	one_class_a: assert property (refresh_pulse |-> $onehot(cls))
		else $error("class not one-hot");
	class_pulse_a: assert property (|cls |-> refresh_pulse)
		else $error("class without refresh");
	reset_mode_a: assert property (disable iff (1'b0) rst |=> stat.mode == 3'h0)
		else $error("mode not reset");
	fixed_class_a: assert property (
		refresh_pulse && !stat.mode[2] |-> cls == (3'h4 >> stat.mode[1:0]))
		else $error("fixed mode class wrong");
	rate_follow_a: assert property (double_rate_refresh |-> ##[0:1] stat.rate == FGR_RATE2)
		else $error("rate not double");
	busy_after_a: assert property (ref_seen |-> busy_soon)
		else $error("no busy after refresh");
	rfc_single_a: assert property (single_rate_refresh |-> ##[0:1] stat.rfc_cyc == RFC1_CYC)
		else $error("single cycle time wrong");
	refi_quad_a: assert property (
		!$past(rst) && $stable(stat.rate) && stat.rate == FGR_RATE4 |-> stat.refi_cyc == REFI_CYC / 4)
		else $error("quad interval wrong");
	tcr_quiet_a: assert property (!tcr_enable [*6] |-> !err_tcr)
		else $error("tcr error while disabled");
endmodule // fgr_chk
`default_nettype wire

// ### bench/fgr_ctl_model.sv
// Controller model driving the command pins.
// Assumes the bench orders the commands.
`timescale 1ns/1ps
`default_nettype none
module fgr_ctl_model (
	input wire logic mclk,
	output fgr_pkg::fgr_cmd_s cmd
);
	import fgr_pkg::*;
	initial begin
		cmd = '1;
	end
	task automatic issue(input fgr_cmd_s c);
		fgr_cmd_s d;
		@(negedge mclk);
		cmd = c;
		d = ~c;
		d.cs_n = 1'b1;
		@(negedge mclk);
		cmd = d;
	endtask
	task automatic refresh(input logic b);
		fgr_cmd_s c;
		c = '0;
		c.act_n = 1'b1;
		c.we_n = 1'b1;
		c.bg0 = b;
		c.addr = 18'h2A5A5;
		issue(c);
	endtask
	task automatic mrs(input logic [2:0] code);
		fgr_cmd_s c;
		c = '0;
		c.act_n = 1'b1;
		c.mr_sel = 2'h3;
		c.addr[8:6] = code;
		issue(c);
	endtask
endmodule // fgr_ctl_model
`default_nettype wire

// ### bench/fgr_refresh_mode_bench.sv
// Bench for the refresh mode block.
// Assumes a shortened refresh interval and the controller model.
`timescale 1ns/1ps
`default_nettype none
module fgr_refresh_mode_bench;
	import fgr_pkg::*;
	localparam int REFI = 40;
	localparam logic [23:0] CODES = 24'h1BD899;
	localparam logic [23:0] EXPS = 24'h1AD489;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic tcr_enable = 1'b0;
	fgr_cmd_s cmd_pin;
	fgr_stat_s stat;
	logic s1, s2, s4, rp, e_cnt, e_tcr, e_type, e_busy;
	int num_errors = 0;
	int checked = 0;
	always #4 mclk = ~mclk;
	fgr_ctl_model u_ctl (.mclk(mclk), .cmd(cmd_pin));
	fgr_refresh_mode #(.REFI_CYC(REFI)) dut (
		.mclk(mclk), .rst(rst), .cmd_pin(cmd_pin), .tcr_enable(tcr_enable),
		.stat(stat), .single_rate_refresh(s1), .double_rate_refresh(s2),
		.quad_rate_refresh(s4), .refresh_pulse(rp), .err_type(e_type), .err_count(e_cnt),
		.err_busy(e_busy), .err_tcr(e_tcr)
	);
	task automatic print_verdict;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			num_errors++;
			print_verdict();
		end
	endtask
	task automatic do_ref(input logic b, input logic [2:0] cls, input logic err);
		int n;
		u_ctl.refresh(b);
		for (n = 0; rp !== 1'b1 && n < 8; n++) begin
			@(negedge mclk);
		end
		tmo(n, 8);
		chk("class", {s1, s2, s4}, cls);
		chk("type err", e_type, 1'b0);
		chk("count err", e_cnt, err);
		@(negedge mclk);
		for (n = 0; stat.busy !== 1'b0 && n < 100; n++) begin
			@(negedge mclk);
		end
		tmo(n, 100);
	endtask
	task automatic do_mrs(input logic [2:0] code, input logic [2:0] mode, input logic err);
		logic ec;
		ec = 1'b0;
		u_ctl.mrs(code);
		repeat (6) begin
			@(negedge mclk);
			ec = ec | e_cnt;
		end
		chk("mode", stat.mode, mode);
		chk("mrs count err", ec, err);
	endtask
	task automatic t_modes;
		chk("reset mode", stat.mode, 3'h0);
		chk("reset rate", stat.rate, FGR_RATE1);
		for (int i = 0; i < 8; i++) begin
			do_mrs(CODES[3*i +: 3], EXPS[3*i +: 3], 1'b0);
		end
	endtask
	task automatic t_quad;
		do_ref(1'b0, 3'h4, 1'b0);
		do_mrs(3'h2, 3'h2, 1'b0);
		repeat (3) do_ref(1'b1, 3'h1, 1'b0);
		chk("refi", stat.refi_cyc, REFI / 4);
		do_mrs(3'h6, 3'h6, 1'b0);
		do_ref(1'b1, 3'h1, 1'b0);
		do_ref(1'b0, 3'h4, 1'b0);
		do_ref(1'b1, 3'h1, 1'b0);
		do_ref(1'b0, 3'h4, 1'b1);
		do_mrs(3'h2, 3'h2, 1'b0);
		repeat (3) do_ref(1'b0, 3'h1, 1'b0);
		do_mrs(3'h0, 3'h0, 1'b1);
	endtask
	task automatic t_double;
		do_mrs(3'h5, 3'h5, 1'b0);
		repeat (2) do_ref(1'b1, 3'h2, 1'b0);
		do_ref(1'b0, 3'h4, 1'b0);
		do_ref(1'b1, 3'h2, 1'b0);
		chk("rate", stat.rate, FGR_RATE2);
		do_ref(1'b0, 3'h4, 1'b1);
		do_ref(1'b1, 3'h2, 1'b0);
		do_mrs(3'h0, 3'h0, 1'b1);
	endtask
	task automatic t_tcr;
		tcr_enable = 1'b1;
		repeat (6) @(negedge mclk);
		chk("tcr idle", e_tcr, 1'b0);
		do_mrs(3'h1, 3'h1, 1'b0);
		chk("tcr err", e_tcr, 1'b1);
		tcr_enable = 1'b0;
		repeat (8) @(negedge mclk);
		chk("tcr clear", e_tcr, 1'b0);
	endtask
	task automatic t_busy;
		logic eb;
		int n;
		eb = 1'b0;
		u_ctl.refresh(1'b0);
		u_ctl.mrs(3'h3);
		for (n = 0; n < 8; n++) begin
			@(negedge mclk);
			eb = eb | e_busy;
		end
		chk("busy err", eb, 1'b1);
		chk("reserved write", stat.mode, 3'h1);
		for (n = 0; stat.busy !== 1'b0 && n < 100; n++) begin
			@(negedge mclk);
		end
		tmo(n, 100);
		chk("busy idle", e_busy, 1'b0);
	endtask
	task automatic t_reset;
		rst = 1'b1;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		chk("rerun mode", stat.mode, 3'h0);
		chk("rerun rate", stat.rate, FGR_RATE1);
		chk("rerun refi", stat.refi_cyc, REFI);
	endtask
	initial begin
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		t_modes;
		t_quad;
		t_double;
		t_tcr;
		t_busy;
		t_reset;
		print_verdict;
	end
endmodule // fgr_refresh_mode_bench
bind fgr_refresh_mode fgr_chk #(.REFI_CYC(REFI_CYC)) u_chk (
	.mclk(mclk), .rst(rst), .tcr_enable(tcr_enable), .stat(stat),
	.single_rate_refresh(single_rate_refresh), .double_rate_refresh(double_rate_refresh),
	.quad_rate_refresh(quad_rate_refresh), .refresh_pulse(refresh_pulse), .err_tcr(err_tcr)
);
`default_nettype wire
